// file: core/pcam_regs.vh
// Register addresses, field positions and reset values for the counter array mode block
`ifndef PCAM_REGS_VH
`define PCAM_REGS_VH
`define PCAM_ADDR_MODE0    8'hda
`define PCAM_ADDR_MODE1    8'hdb
`define PCAM_ADDR_MODE2    8'hdc
`define PCAM_ADDR_CNT_LOW  8'hf9
`define PCAM_ADDR_CPL0     8'hfb
`define PCAM_ADDR_CPH0     8'hfc
`define PCAM_ADDR_CPL1     8'he9
`define PCAM_ADDR_CPH1     8'hea
`define PCAM_ADDR_CPL2     8'heb
`define PCAM_ADDR_CPH2     8'hec
`define PCAM_BIT_WIDE      7
`define PCAM_BIT_COMP      6
`define PCAM_BIT_RISE      5
`define PCAM_BIT_FALL      4
`define PCAM_BIT_MATCH     3
`define PCAM_BIT_TOGGLE    2
`define PCAM_BIT_PWM       1
`define PCAM_BIT_IRQEN     0
`define PCAM_MODE_RESET    8'h00
`define PCAM_BYTE_RESET    8'h00
`define PCAM_WDOG_MODULE   2
`endif

// file: core/pcam_channel.v
// One capture/compare channel: mode register, compare, capture and output logic
`timescale 1ns/1ns
`include "pcam_regs.vh"
module pcam_channel
#(
  parameter CW = 16
)
(
  input  wire          mclk_i,
  input  wire          rst_b_i,
  input  wire          ce_i,
  input  wire          mode_we_i,
  input  wire          cpl_we_i,
  input  wire          cph_we_i,
  input  wire [7:0]    wdata_i,
  input  wire          wdog_lock_i,
  input  wire [CW-1:0] counter_i,
  input  wire          cnt_tick_i,
  input  wire          edge_rise_i,
  input  wire          edge_fall_i,
  input  wire          flag_clear_i,
  output wire [7:0]    mode_o,
  output wire [CW-1:0] capcmp_o,
  output wire          flag_o,
  output wire          pin_o
);
  reg  [7:0]    mode;
  reg  [CW-1:0] capcmp;
  reg           flag;
  reg           pin;
  wire       low_match;
  wire       full_match;
  wire       match;
  wire       wide;
  wire       capture;
  reg  [7:0] next_mode;

  assign mode_o     = mode;
  assign capcmp_o   = capcmp;
  assign flag_o     = flag;
  assign pin_o      = pin;
  assign wide       = mode[`PCAM_BIT_WIDE];
  assign low_match  = counter_i[7:0] == capcmp[7:0];
  assign full_match = counter_i == capcmp;
  assign match      = mode[`PCAM_BIT_COMP] & cnt_tick_i & (wide ? full_match : low_match);
  assign capture    = (mode[`PCAM_BIT_RISE] & edge_rise_i) | (mode[`PCAM_BIT_FALL] & edge_fall_i);

  always @*
  begin
    next_mode = mode;
    if (mode_we_i && !wdog_lock_i)  // see RULE12
      next_mode = wdata_i;
    if (cpl_we_i)
      next_mode[`PCAM_BIT_COMP] = 1'b0;  // see RULE10
    if (cph_we_i)
      next_mode[`PCAM_BIT_COMP] = 1'b1;  // see RULE11
  end

  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mode   <= `PCAM_MODE_RESET;
      capcmp <= {CW{1'b0}};
      flag   <= 1'b0;
      pin    <= 1'b0;
    end
    else if (ce_i)
    begin
      mode <= next_mode;
      if (cpl_we_i)
        capcmp[7:0] <= wdata_i;
      else if (capture)
        capcmp <= counter_i;  // see RULE2
      if (cph_we_i)
        capcmp[CW-1:8] <= wdata_i;
      // Set wins over software clear
      if ((match && mode[`PCAM_BIT_MATCH]) || capture)
        flag <= 1'b1;  // see RULE3 see RULE4 see RULE9
      else if (flag_clear_i)
        flag <= 1'b0;
      if (mode[`PCAM_BIT_PWM] && mode[`PCAM_BIT_COMP] && !mode[`PCAM_BIT_TOGGLE])
      begin
        // High from match until wrap: 8-bit or 16-bit period
        if (match)
          pin <= 1'b1;  // see RULE1 see RULE8
        else if (cnt_tick_i && (wide ? (counter_i == {CW{1'b0}})
                                     : (counter_i[7:0] == 8'h00)))
          pin <= 1'b0;  // see RULE1
      end
      else if (mode[`PCAM_BIT_TOGGLE] && match)
        pin <= ~pin;  // see RULE5
    end
  end
endmodule // pcam_channel

// file: core/pcam_top.v
// Counter array mode control and counter low byte, three channels
`timescale 1ns/1ns
`include "pcam_regs.vh"
// Behaviour
// RULE1: Modulation runs 8-bit when wide select is 0, 16-bit when 1.
// RULE2: Rise or fall capture enable latches counter on matching input edge.
// RULE3: Match enable sets event flag when counter equals compare value.
// RULE4: Counter match raises the same event flag that captures set.
// RULE5: Toggle enable inverts output pin at each match; with modulation gives frequency output.
// RULE6: Counter low byte reads and writes counter bits 7 to 0.
// RULE7: Writes to counter low byte are ignored while watchdog is enabled.
// RULE8: Modulation enable with comparator enable drives modulated waveform on output pin.
// RULE9: Event flag set by hardware, cleared only by software; interrupt requested while set. The code requests it only while mode bit 0 is also 1.
// RULE10: Writing compare low byte clears comparator enable.
// RULE11: Writing compare high byte sets comparator enable.
// RULE12: With watchdog enabled, channel 2 mode register writes are blocked.
module pcam_top
#(
  parameter NCH = 3,
  parameter CW  = 16
)
(
  input  wire           mclk_i,
  input  wire           rst_b_i,
  input  wire           ce_i,
  input  wire [7:0]     sfr_addr_i,
  input  wire [7:0]     sfr_wdata_i,
  input  wire           sfr_we_i,
  input  wire           sfr_re_i,
  output reg  [7:0]     sfr_rdata_o,
  input  wire           watchdog_enable_i,
  input  wire           cnt_tick_i,
  input  wire [7:0]     cnt_high_i,
  input  wire [NCH-1:0] module_input_i,
  input  wire [NCH-1:0] flag_clear_i,
  output reg  [CW-1:0]  counter_o,
  output reg  [NCH-1:0] module_event_flag_o,
  output reg  [NCH-1:0] module_output_pin_o,
  output reg            array_irq_o
);
  reg  [1:0]     rst_sync;
  wire           rst_b;
  reg  [7:0]     cnt_low;
  reg  [NCH-1:0] in_s1;
  reg  [NCH-1:0] in_s2;
  reg  [NCH-1:0] in_s3;
  reg  [NCH-1:0] in_lvl;
  wire [NCH-1:0] rise;
  wire [NCH-1:0] fall;
  wire [7:0]     mode_w  [0:NCH-1];
  wire [CW-1:0]  cap_w   [0:NCH-1];
  wire [NCH-1:0] flag_w;
  wire [NCH-1:0] pin_w;
  wire [CW-1:0]  counter;
  wire           low_we;
  reg  [7:0]     next_rdata;
  reg            next_irq;
  integer        k;

  assign rst_b   = rst_sync[1];
  assign counter = {cnt_high_i, cnt_low};
  assign low_we  = sfr_we_i && (sfr_addr_i == `PCAM_ADDR_CNT_LOW) && !watchdog_enable_i;  // see RULE7

  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  // Input edge detection: change accepted once stages two and three agree
  assign rise = in_s2 & in_s3 & ~in_lvl;
  assign fall = ~in_s2 & ~in_s3 & in_lvl;

  always @(posedge mclk_i or negedge rst_b)
  begin
    if (!rst_b)
    begin
      in_s1  <= {NCH{1'b0}};
      in_s2  <= {NCH{1'b0}};
      in_s3  <= {NCH{1'b0}};
      in_lvl <= {NCH{1'b0}};
    end
    else if (ce_i)
    begin
      in_s1 <= module_input_i;
      in_s2 <= in_s1;
      in_s3 <= in_s2;
      for (k = 0; k < NCH; k = k + 1)
        if (in_s2[k] == in_s3[k])
          in_lvl[k] <= in_s2[k];
    end
  end

  always @(posedge mclk_i or negedge rst_b)
  begin
    if (!rst_b)
      cnt_low <= `PCAM_BYTE_RESET;
    else if (ce_i)
    begin
      if (low_we)
        cnt_low <= sfr_wdata_i;  // see RULE6
      else if (cnt_tick_i)
        cnt_low <= cnt_low + 8'h01;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_ch
      wire [31:0] a_mode_full = `PCAM_ADDR_MODE0 + g;
      wire [7:0]  a_mode      = a_mode_full[7:0];
      wire [7:0] a_cpl  = (g == 0) ? `PCAM_ADDR_CPL0 : (g == 1) ? `PCAM_ADDR_CPL1 : `PCAM_ADDR_CPL2;
      wire [7:0] a_cph  = (g == 0) ? `PCAM_ADDR_CPH0 : (g == 1) ? `PCAM_ADDR_CPH1 : `PCAM_ADDR_CPH2;
      pcam_channel #(.CW(CW)) u_ch
      (
        .mclk_i       (mclk_i),
        .rst_b_i      (rst_b),
        .ce_i         (ce_i),
        .mode_we_i    (sfr_we_i && sfr_addr_i == a_mode),
        .cpl_we_i     (sfr_we_i && sfr_addr_i == a_cpl),
        .cph_we_i     (sfr_we_i && sfr_addr_i == a_cph),
        .wdata_i      (sfr_wdata_i),
        .wdog_lock_i  (watchdog_enable_i && g == `PCAM_WDOG_MODULE),  // see RULE12
        .counter_i    (counter),
        .cnt_tick_i   (cnt_tick_i),
        .edge_rise_i  (rise[g]),
        .edge_fall_i  (fall[g]),
        .flag_clear_i (flag_clear_i[g]),
        .mode_o       (mode_w[g]),
        .capcmp_o     (cap_w[g]),
        .flag_o       (flag_w[g]),
        .pin_o        (pin_w[g])
      );
    end
  endgenerate

  always @*
  begin
    next_rdata = 8'h00;
    next_irq   = 1'b0;
    if (sfr_addr_i == `PCAM_ADDR_CNT_LOW)
      next_rdata = cnt_low;  // see RULE6
    for (k = 0; k < NCH; k = k + 1)
    begin
      if (sfr_addr_i == `PCAM_ADDR_MODE0 + k[7:0])
        next_rdata = mode_w[k];
      if (flag_w[k] && mode_w[k][`PCAM_BIT_IRQEN])
        next_irq = 1'b1;  // see RULE9
    end
  end

  always @(posedge mclk_i or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sfr_rdata_o         <= 8'h00;
      counter_o           <= {CW{1'b0}};
      module_event_flag_o <= {NCH{1'b0}};
      module_output_pin_o <= {NCH{1'b0}};
      array_irq_o         <= 1'b0;
    end
    else if (ce_i)
    begin
      if (sfr_re_i)
        sfr_rdata_o <= next_rdata;
      counter_o           <= counter;
      module_event_flag_o <= flag_w;
      module_output_pin_o <= pin_w;
      array_irq_o         <= next_irq;
    end
  end
endmodule // pcam_top

// file: tb/pcam_properties.sv
// Port-level checks for the counter array mode block
`timescale 1ns/1ns
module pcam_properties
#(
  parameter NCH = 3,
  parameter CW  = 16
)
(
  input wire           mclk_i,
  input wire           rst_b_i,
  input wire           ce_i,
  input wire [7:0]     sfr_addr_i,
  input wire [7:0]     sfr_wdata_i,
  input wire           sfr_we_i,
  input wire           sfr_re_i,
  input wire [7:0]     sfr_rdata_o,
  input wire           watchdog_enable_i,
  input wire           cnt_tick_i,
  input wire [7:0]     cnt_high_i,
  input wire [NCH-1:0] module_input_i,
  input wire [NCH-1:0] flag_clear_i,
  input wire [CW-1:0]  counter_o,
  input wire [NCH-1:0] module_event_flag_o,
  input wire [NCH-1:0] module_output_pin_o,
  input wire           array_irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  wire lw = sfr_we_i && ce_i && sfr_addr_i == 8'hf9 && !watchdog_enable_i;
  wire rq = sfr_re_i && ce_i;
  a_low_step: assert property (!$past(lw, 2) && $past(ce_i) && $past(ce_i, 2) |->
    counter_o[7:0] == $past(counter_o[7:0]) + $past(cnt_tick_i && ce_i, 2)) else $error("low step");
  a_high_copy: assert property ($past(ce_i) |->
    counter_o[15:8] == $past(cnt_high_i)) else $error("high byte");
  a_low_read: assert property (rq && sfr_addr_i == 8'hf9 |=>
    sfr_rdata_o == counter_o[7:0]) else $error("low read");
  a_unmapped_zero: assert property (rq && !(sfr_addr_i inside {8'hda, 8'hdb, 8'hdc, 8'hf9})
    |=> sfr_rdata_o == 8'h00) else $error("unmapped read");
  a_rdata_hold: assert property (!$past(rq) |-> $stable(sfr_rdata_o)) else $error("rdata moved");
  a_mode_back: assert property (sfr_we_i && ce_i && sfr_addr_i == 8'hda ##1 !sfr_we_i
    ##1 rq && !sfr_we_i && sfr_addr_i == 8'hda |=> sfr_rdata_o == $past(sfr_wdata_i, 3))
    else $error("mode readback");
  a_flag_sticky: assert property (($past(module_event_flag_o) & ~module_event_flag_o
    & ~$past(flag_clear_i, 2)) == '0) else $error("flag dropped");
  a_irq_flag: assert property (array_irq_o |->
    |($past(module_event_flag_o) | module_event_flag_o)) else $error("irq without flag");
  c_flag: cover property (|module_event_flag_o);
  c_irq: cover property (array_irq_o);
  c_pin: cover property (|module_output_pin_o);
endmodule // pcam_properties
bind pcam_top pcam_properties #(.NCH(NCH), .CW(CW)) u_props (.mclk_i, .rst_b_i, .ce_i,
  .sfr_addr_i, .sfr_wdata_i, .sfr_we_i, .sfr_re_i, .sfr_rdata_o, .watchdog_enable_i,
  .cnt_tick_i, .cnt_high_i, .module_input_i, .flag_clear_i, .counter_o,
  .module_event_flag_o, .module_output_pin_o, .array_irq_o);

// file: tb/pcam_top_tb.sv
// Self-checking bench for the counter array mode block
`timescale 1ns/1ns
module pcam_top_tb;
  reg        mclk_i = 0, rst_b_i = 0, sfr_we_i = 0, sfr_re_i = 0;
  reg        cnt_tick_i = 0, watchdog_enable_i = 0, ce_i = 1;
  reg  [7:0] sfr_addr_i = 0, sfr_wdata_i = 0, cnt_high_i = 0, v;
  reg  [2:0] module_input_i = 0, flag_clear_i = 0;
  wire [7:0] sfr_rdata_o;
  wire [15:0] counter_o;
  wire [2:0] module_event_flag_o, module_output_pin_o;
  wire       array_irq_o;
  wire [5:0] obs = {module_output_pin_o, module_event_flag_o};
  integer    errors = 0, check_count = 0, seed = 32'h21ed6386, i, n;
  pcam_top uut (.mclk_i, .rst_b_i, .ce_i, .sfr_addr_i, .sfr_wdata_i, .sfr_we_i,
    .sfr_re_i, .sfr_rdata_o, .watchdog_enable_i, .cnt_tick_i, .cnt_high_i, .module_input_i,
    .flag_clear_i, .counter_o, .module_event_flag_o, .module_output_pin_o, .array_irq_o);
  initial
    forever #5 mclk_i = ~mclk_i;
  task results;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input [7:0] s, input [7:0] e);
    check_count = check_count + 1;
    if (s !== e)
    begin
      errors = errors + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge mclk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_we_i <= 1'b1;
    @(posedge mclk_i);
    sfr_we_i <= 1'b0;
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    @(posedge mclk_i);
    sfr_addr_i <= a;
    sfr_re_i <= 1'b1;
    @(posedge mclk_i);
    sfr_re_i <= 1'b0;
    @(posedge mclk_i);
    #1 chk(sfr_rdata_o, e);
  endtask
  task tick(input integer k);
    repeat (k)
    begin
      @(posedge mclk_i);
      cnt_tick_i <= 1'b1;
    end
    @(posedge mclk_i);
    cnt_tick_i <= 1'b0;
  endtask
  task wt(input integer b);
    i = 0;
    while (obs[b] !== 1'b1 && i < 20)
    begin
      @(posedge mclk_i);
      #1 i = i + 1;
    end
    if (i == 20)
    begin
      errors = errors + 1;
      results;
    end
  endtask
  initial
  begin
    repeat (20) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rdc(8'hda, 8'h00);
    rdc(8'hdc, 8'h00);
    rdc(8'hf9, 8'h00);
    rdc(8'h42, 8'h00);
    for (n = 0; n < 4; n = n + 1)
    begin
      v = $random(seed);
      wr(8'hda, v);
      rdc(8'hda, v);
    end
    wr(8'hf9, 8'h10);
    watchdog_enable_i <= 1'b1;
    wr(8'hf9, 8'h77);
    wr(8'hdc, 8'hff);
    rdc(8'hdc, 8'h00);
    rdc(8'hf9, 8'h10);
    watchdog_enable_i <= 1'b0;
    ce_i <= 1'b0;
    wr(8'hf9, 8'h33);
    ce_i <= 1'b1;
    rdc(8'hf9, 8'h10);
    wr(8'hda, 8'h49);
    wr(8'hfb, 8'h14);
    rdc(8'hda, 8'h09);
    wr(8'hfc, 8'h00);
    rdc(8'hda, 8'h49);
    tick(5);
    wt(0);
    chk(array_irq_o, 8'h01);
    flag_clear_i <= 3'h1;
    @(posedge mclk_i);
    flag_clear_i <= 3'h0;
    repeat (3) @(posedge mclk_i);
    #1 chk({array_irq_o, module_event_flag_o[0]}, 8'h00);
    wr(8'hdb, 8'h44);
    wr(8'he9, 8'h1b);
    wr(8'hea, 8'h00);
    tick(7);
    wt(4);
    chk(module_output_pin_o[1], 8'h01);
    wr(8'hda, 8'h42);
    wr(8'hfb, 8'h20);
    wr(8'hfc, 8'h00);
    rdc(8'hda, 8'h42);
    tick(5);
    wt(3);
    chk(module_output_pin_o[0], 8'h01);
    tick(223);
    repeat (2) @(posedge mclk_i);
    #1 chk(module_output_pin_o[0], 8'h01);
    tick(1);
    repeat (2) @(posedge mclk_i);
    #1 chk(module_output_pin_o[0], 8'h00);
    wr(8'hdc, 8'h21);
    module_input_i <= 3'h4;
    wt(2);
    chk({array_irq_o, module_event_flag_o[2]}, 8'h03);
    results;
  end
endmodule // pcam_top_tb
